// [src/bcfg_decoder.sv]
// configuration byte decoder: latches and interprets the first six bytes, except reserved byte three
`timescale 1ns/10ps
`default_nettype none

// Function
// - byte zero must read 0x53 to validate
// - byte one must read 0x4b too
// - nonzero level on ata drive with pm support issues enable
// - zero level skips power management command
// - atapi drives ignore power management level
// - matching first cb byte selects vendor decode
// - bit five reports write caching page
// - bit four polls status instead of intrq
// - bit three enables 120 ms drq delay
// - bit two forces short packet before stall
module bcfg_decoder #(
   parameter int unsigned DELAY_CYCLES = bcfg_pkg::busy_delay_cyc
) (
   // clock and reset
   input  wire logic                    sys_clk_i,
   input  wire logic                    reset_i,
   // bytes from the eeprom reader
   input  wire bcfg_pkg::bcfg_byte_type cfg_byte_i,
   input  wire logic                    cfg_done_i,
   // drive initialization request
   input  wire logic                    init_start_i,
   input  wire logic                    drive_is_atapi_i,
   input  wire logic                    drive_has_pm_i,
   // command block first byte
   input  wire logic                    cb_valid_i,
   input  wire logic [7:0]              cb_byte0_i,
   // drq read with length mismatch
   input  wire logic                    drq_read_i,
   input  wire logic                    len_mismatch_i,
   // decoded controls
   output bcfg_pkg::bcfg_ctrl_type      ctrl_o,
   output logic                         cfg_ready_o,
   // power management command request
   output logic                         pm_cmd_o,
   output logic [7:0]                   pm_level_o,
   // command block classification
   output logic                         cb_vendor_o,
   output logic                         cb_atapi_o,
   // drq read may proceed
   output logic                         drq_go_o
);
   localparam int unsigned DW = $clog2(DELAY_CYCLES + 1);

   // latched configuration bytes
   logic [7:0]    sig_low_q;
   logic [7:0]    sig_high_q;
   logic [7:0]    pm_level_q;
   logic [7:0]    vendor_q;
   logic [7:0]    flags_q;
   logic          loaded_q;          // all bytes taken
   logic          pm_cmd_q;
   logic          cb_vendor_q;
   logic          cb_atapi_q;
   logic [DW-1:0] delay_cnt_q;       // busy-bit delay counter
   logic          delaying_q;
   logic          served_q;          // delay already spent on the pending read

   // byte-write decode
   wire take_w     = cfg_byte_i.valid && !loaded_q;
   // both signature bytes must match before the pins count as configured
   wire sig_ok_w   = (sig_low_q == bcfg_pkg::sig_low_value)
                     && (sig_high_q == bcfg_pkg::sig_high_value);
   // power management enable only for an ata drive with a nonzero level
   wire pm_issue_w = init_start_i && loaded_q && !drive_is_atapi_i
                     && drive_has_pm_i && (pm_level_q != 8'h00);
   // first command byte against the stored designator
   wire vend_w     = (cb_byte0_i == vendor_q);
   // busy-bit delay starts once per mismatched read, not again after it expires
   wire delay_en_w = flags_q[bcfg_pkg::busy_delay_bit];
   wire delay_hit_w = drq_read_i && len_mismatch_i && delay_en_w && loaded_q
                      && !served_q;
   wire delay_end_w = (delay_cnt_q == DW'(DELAY_CYCLES - 1));
   wire delay_done_w = delaying_q && delay_end_w;

   // capture configuration bytes until the reader reports done
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         sig_low_q  <= 8'h00;
         sig_high_q <= 8'h00;
         pm_level_q <= bcfg_pkg::pm_level_reset;
         vendor_q   <= bcfg_pkg::vendor_reset;
         flags_q    <= bcfg_pkg::opt_flags_reset;
      end else if (take_w) begin
         unique case (cfg_byte_i.offset)
            bcfg_pkg::sig_low_offset:   sig_low_q  <= cfg_byte_i.data;
            bcfg_pkg::sig_high_offset:  sig_high_q <= cfg_byte_i.data;
            bcfg_pkg::pm_level_offset:  pm_level_q <= cfg_byte_i.data;
            bcfg_pkg::vendor_offset:    vendor_q   <= cfg_byte_i.data;
            bcfg_pkg::opt_flags_offset: flags_q    <= cfg_byte_i.data;
            default: ;                  // reserved and later bytes ignored
         endcase
      end
   end

   // loaded flag gates init and command handling
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         loaded_q <= 1'b0;
      end else if (cfg_done_i) begin
         loaded_q <= 1'b1;
      end
   end

   // power management request and command classification
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         pm_cmd_q    <= 1'b0;
         cb_vendor_q <= 1'b0;
         cb_atapi_q  <= 1'b0;
      end else begin
         pm_cmd_q    <= pm_issue_w;
         cb_vendor_q <= cb_valid_i && loaded_q && vend_w;
         cb_atapi_q  <= cb_valid_i && loaded_q && !vend_w;
      end
   end

   // busy-bit delay counter at mismatched drq reads
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         delaying_q  <= 1'b0;
         delay_cnt_q <= '0;
      end else if (delaying_q) begin
         delay_cnt_q <= delay_end_w ? '0 : delay_cnt_q + 1'b1;
         delaying_q  <= !delay_end_w;
      end else if (delay_hit_w) begin
         delaying_q  <= 1'b1;
         delay_cnt_q <= '0;
      end
   end

   // a finished delay lets the pending read through until it drops
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         served_q <= 1'b0;
      end else if (!drq_read_i) begin
         served_q <= 1'b0;              // read over, the next one is new
      end else if (delay_done_w) begin
         served_q <= 1'b1;
      end
   end

   // outputs
   assign cfg_ready_o = loaded_q;
   assign pm_cmd_o    = pm_cmd_q;
   assign pm_level_o  = pm_level_q;
   assign cb_vendor_o = cb_vendor_q;
   assign cb_atapi_o  = cb_atapi_q;
   assign drq_go_o    = drq_read_i && !delaying_q && !delay_hit_w;
   // one pattern so the control struct has a single driver
   assign ctrl_o = '{
      config_valid:          loaded_q && sig_ok_w,
      mode_page8_en:         flags_q[bcfg_pkg::mode_page8_bit],
      poll_status:           flags_q[bcfg_pkg::poll_status_bit],
      busy_delay_en:         delay_en_w,
      short_pkt_en:          flags_q[bcfg_pkg::short_pkt_bit],
      vendor_cmd_designator: vendor_q
   };

   // assertions
   a_sig_check: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      ctrl_o.config_valid |-> sig_low_q == 8'h53) else $error("bad signature low");
   a_sig_high: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      ctrl_o.config_valid |-> sig_high_q == 8'h4b) else $error("bad signature high");
   a_pm_issue: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      init_start_i && loaded_q && !drive_is_atapi_i && drive_has_pm_i && pm_level_q != 8'h00
      |=> pm_cmd_o) else $error("pm command missing");
   a_pm_zero: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      pm_cmd_o |-> $past(pm_level_q) != 8'h00) else $error("pm command on zero");
   a_pm_atapi: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      pm_cmd_o |-> !$past(drive_is_atapi_i)) else $error("pm command to atapi");
   a_vendor_match: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      cb_valid_i && loaded_q && cb_byte0_i == vendor_q |=> cb_vendor_o && !cb_atapi_o)
      else $error("vendor cb missed");
   a_page8_flag: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      ctrl_o.mode_page8_en == flags_q[5]) else $error("page 8 flag wrong");
   a_poll_flag: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      ctrl_o.poll_status == flags_q[4]) else $error("poll flag wrong");
   a_delay_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      delay_hit_w && !delaying_q |=> delaying_q && !drq_go_o) else $error("delay skipped");
   a_short_pkt: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      ctrl_o.short_pkt_en == flags_q[2]) else $error("short packet flag wrong");
   a_load_first: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      !loaded_q |=> !pm_cmd_o && !cb_vendor_o && !cb_atapi_o) else $error("acted before load");
   // power management skipped on a zero level
   a_pm_skip: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      init_start_i && loaded_q && pm_level_q == 8'h00 |=> !pm_cmd_o)
      else $error("pm command despite zero level");
   // any other first byte goes down the atapi path
   a_cb_atapi: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      cb_valid_i && loaded_q && cb_byte0_i != vendor_q |=> cb_atapi_o && !cb_vendor_o)
      else $error("atapi cb missed");
   // option flags follow the stored byte
   a_page8_load: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      take_w && cfg_byte_i.offset == bcfg_pkg::opt_flags_offset
      |=> ctrl_o.mode_page8_en == $past(cfg_byte_i.data[5])) else $error("page 8 not taken");
   a_poll_load: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      take_w && cfg_byte_i.offset == bcfg_pkg::opt_flags_offset
      |=> ctrl_o.poll_status == $past(cfg_byte_i.data[4])) else $error("poll not taken");
   a_delay_load: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      take_w && cfg_byte_i.offset == bcfg_pkg::opt_flags_offset
      |=> ctrl_o.busy_delay_en == $past(cfg_byte_i.data[3])) else $error("delay not taken");
   a_short_load: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      take_w && cfg_byte_i.offset == bcfg_pkg::opt_flags_offset
      |=> ctrl_o.short_pkt_en == $past(cfg_byte_i.data[2])) else $error("short not taken");
   // busy-bit delay counts from zero and releases the pending read
   a_delay_start: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      $rose(delaying_q) |-> delay_cnt_q == '0) else $error("delay count not cleared");
   a_delay_release: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      delay_done_w && drq_read_i |=> drq_go_o == drq_read_i)
      else $error("read held after delay");
   // bytes stay frozen once loading is over
   a_bytes_frozen: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      loaded_q |=> $stable(pm_level_q) && $stable(vendor_q) && $stable(flags_q))
      else $error("bytes changed after load");
   // scenario covers
   c_load: cover property (@(posedge sys_clk_i) disable iff (reset_i) ctrl_o.config_valid);
   c_pm: cover property (@(posedge sys_clk_i) disable iff (reset_i) pm_cmd_o);
   c_vendor: cover property (@(posedge sys_clk_i) disable iff (reset_i) cb_vendor_o);
   c_delay: cover property (@(posedge sys_clk_i) disable iff (reset_i) delaying_q && delay_end_w);
   c_atapi: cover property (@(posedge sys_clk_i) disable iff (reset_i) cb_atapi_o);
endmodule

`default_nettype wire

// [src/bcfg_pkg.sv]
// package of constants and carriers for the configuration byte decoder
package bcfg_pkg;
   // configuration byte offsets
   localparam logic [7:0] sig_low_offset   = 8'h00;
   localparam logic [7:0] sig_high_offset  = 8'h01;
   localparam logic [7:0] pm_level_offset  = 8'h02;
   localparam logic [7:0] rsvd_offset      = 8'h03;
   localparam logic [7:0] vendor_offset    = 8'h04;
   localparam logic [7:0] opt_flags_offset = 8'h05;
   localparam logic [7:0] last_offset      = 8'h05;
   // required signature values
   localparam logic [7:0] sig_low_value    = 8'h53;
   localparam logic [7:0] sig_high_value   = 8'h4b;
   // reset values of latched bytes (variable-content defaults)
   localparam logic [7:0] pm_level_reset   = 8'h00;
   localparam logic [7:0] vendor_reset     = 8'h24;
   localparam logic [7:0] opt_flags_reset  = 8'h07;
   // option flag positions
   localparam int unsigned mode_page8_bit  = 5;
   localparam int unsigned poll_status_bit = 4;
   localparam int unsigned busy_delay_bit  = 3;
   localparam int unsigned short_pkt_bit   = 2;
   // eeprom strap addresses the bridge may use
   localparam logic [2:0] eeprom_addr_a    = 3'h2;
   localparam logic [2:0] eeprom_addr_b    = 3'h4;
   // busy-bit delay, in ms, and in cycles at 100 MHz
   localparam int unsigned busy_delay_ms   = 120;
   localparam int unsigned clk_mhz         = 100;
   localparam int unsigned busy_delay_cyc  = busy_delay_ms * 1000 * clk_mhz;

   // one byte arriving from the eeprom reader
   typedef struct packed {
      logic       valid;
      logic [7:0] offset;
      logic [7:0] data;
   } bcfg_byte_type;

   // decoded controls handed to the rest of the bridge
   typedef struct packed {
      logic       config_valid;
      logic       mode_page8_en;
      logic       poll_status;
      logic       busy_delay_en;
      logic       short_pkt_en;
      logic [7:0] vendor_cmd_designator;
   } bcfg_ctrl_type;
endpackage

// [testbench/bcfg_eeprom_model.sv]
// serial eeprom model streaming the first six configuration bytes
`timescale 1ns/10ps
`default_nettype none
module bcfg_eeprom_model #(
   parameter logic [2:0] STRAP_ADDR = bcfg_pkg::eeprom_addr_a  // strapped device address
) (
   // clock and read-out trigger
   input  wire logic                    sys_clk_i,
   input  wire logic                    start_i,
   input  wire logic [47:0]             image_i,
   // bytes toward the decoder
   output bcfg_pkg::bcfg_byte_type      cfg_byte_o,
   output logic                         cfg_done_o
);
   // only a part strapped at 2 or 4 is found by the bridge
   localparam logic strap_ok = (STRAP_ADDR == 3'h2) || (STRAP_ADDR == 3'h4);
   logic [2:0] idx_q = 3'h7;  // offset being sent, 7 when idle
   logic       on_w;          // a byte is on the lines
   // step through offsets 0..5, then one done cycle
   always_ff @(posedge sys_clk_i) begin
      if (start_i) begin
         idx_q <= 3'h0;
      end else if (idx_q != 3'h7) begin
         idx_q <= idx_q + 3'h1;
      end
   end
   assign on_w = strap_ok && (idx_q < 3'h6);
   // signatures travel at offsets 0 and 1; idle lines show the inverse of the last byte
   assign cfg_byte_o = '{valid: on_w, offset: {5'h00, idx_q},
                         data: on_w ? image_i[{idx_q, 3'h0} +: 8] : ~image_i[47:40]};
   assign cfg_done_o = strap_ok && (idx_q == 3'h6);
endmodule
`default_nettype wire

// [testbench/tb_bcfg_decoder.sv]
// self-checking testbench of the configuration byte decoder
`timescale 1ns/10ps
`default_nettype none
module tb_bcfg_decoder;
   logic                    sys_clk_i = 1'b0;
   logic                    reset_i = 1'b1;
   logic                    start = 1'b0;
   logic [47:0]             image = 48'h0;
   logic                    init_s = 1'b0, atapi = 1'b0, has_pm = 1'b0;
   logic                    cb_v = 1'b0, drq = 1'b0, mis = 1'b0;
   logic [7:0]              cb_b = 8'h00;
   bcfg_pkg::bcfg_byte_type cfg_byte;
   bcfg_pkg::bcfg_ctrl_type ctrl;
   logic                    done, rdy, pm_cmd, cb_ven, cb_ata, go;
   logic [7:0]              pm_lvl;
   // validity and option flags as one byte: valid, page8, poll, delay, short
   wire logic [7:0]         flags_v = {3'h0, ctrl.config_valid, ctrl.mode_page8_en,
                                       ctrl.poll_status, ctrl.busy_delay_en, ctrl.short_pkt_en};
   int                      err_count = 0, comparisons = 0, cyc = 0;
   // free-running 100 MHz clock
   always #5 sys_clk_i = ~sys_clk_i;
   bcfg_eeprom_model bcfg_eeprom_model_i (.sys_clk_i(sys_clk_i), .start_i(start),
      .image_i(image), .cfg_byte_o(cfg_byte), .cfg_done_o(done));
   bcfg_decoder #(.DELAY_CYCLES(8)) bcfg_decoder_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
      .cfg_byte_i(cfg_byte), .cfg_done_i(done), .init_start_i(init_s),
      .drive_is_atapi_i(atapi), .drive_has_pm_i(has_pm), .cb_valid_i(cb_v),
      .cb_byte0_i(cb_b), .drq_read_i(drq), .len_mismatch_i(mis), .ctrl_o(ctrl),
      .cfg_ready_o(rdy), .pm_cmd_o(pm_cmd), .pm_level_o(pm_lvl), .cb_vendor_o(cb_ven),
      .cb_atapi_o(cb_ata), .drq_go_o(go));
   // compare tasks for bits and bytes
   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      $display("mismatches %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // hang guard
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         test_done;
      end
   end
   // reset for two cycles
   task automatic do_reset;
      @(posedge sys_clk_i);
      reset_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      reset_i <= 1'b0;
   endtask
   // eeprom read-out, waits for the loaded flag
   task automatic load(input logic [47:0] img);
      int n = 0;
      @(posedge sys_clk_i);
      image <= img;
      start <= 1'b1;
      @(posedge sys_clk_i);
      start <= 1'b0;
      while (rdy !== 1'b1 && n < 20) begin
         @(posedge sys_clk_i);
         #1 n++;
      end
      check_byte({7'h0, rdy}, 8'h01);
   endtask
   // drive init pulse, judge the power management request
   task automatic do_init(input logic at, input logic pm, input logic exp);
      @(posedge sys_clk_i);
      init_s <= 1'b1;
      atapi <= at;
      has_pm <= pm;
      @(posedge sys_clk_i);
      init_s <= 1'b0;
      #1 check_byte({7'h0, pm_cmd}, {7'h0, exp});
   endtask
   // command block first byte, judge the classification pair
   task automatic do_cb(input logic [7:0] b, input logic [1:0] exp);
      @(posedge sys_clk_i);
      cb_v <= 1'b1;
      cb_b <= b;
      @(posedge sys_clk_i);
      cb_v <= 1'b0;
      #1 check_byte({6'h0, cb_ven, cb_ata}, {6'h0, exp});
   endtask
   // drq read, mismatched when m is set, count the cycles until it may proceed
   task automatic do_drq(input logic m, input logic [7:0] exp_n);
      int n = 0;
      @(posedge sys_clk_i);
      drq <= 1'b1;
      mis <= m;
      #1;
      while (go !== 1'b1 && n < 40) begin
         @(posedge sys_clk_i);
         #1 n++;
      end
      check_byte(n[7:0], exp_n);
      // end the read on the next edge
      @(posedge sys_clk_i);
      drq <= 1'b0;
      mis <= 1'b0;
   endtask
   initial begin
      repeat (2) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      #1 check_byte(flags_v, 8'h01);
      check_byte(ctrl.vendor_cmd_designator, 8'h24);
      check_byte({7'h0, rdy}, 8'h00);
      do_cb(8'h24, 2'b00);
      load(48'h38a500054b53);
      check_byte(flags_v, 8'h1e);
      check_byte(ctrl.vendor_cmd_designator, 8'ha5);
      check_byte(pm_lvl, 8'h05);
      do_init(1'b0, 1'b1, 1'b1);
      do_init(1'b1, 1'b1, 1'b0);
      do_init(1'b0, 1'b0, 1'b0);
      do_cb(8'ha5, 2'b10);
      do_cb(8'h24, 2'b01);
      do_drq(1'b1, 8'h09);
      do_drq(1'b0, 8'h00);
      do_reset;
      load(48'h042400004b00);
      check_byte(flags_v, 8'h01);
      do_init(1'b0, 1'b1, 1'b0);
      do_drq(1'b1, 8'h00);
      do_reset;
      load(48'h3824000000_53);
      check_byte({7'h0, ctrl.config_valid}, 8'h00);
      test_done;
   end
endmodule
`default_nettype wire
